// >>> hdl/boot_loader_map.svh
// Offsets, codes and timing constants of the boot select loader
`ifndef BOOT_LOADER_MAP_SVH
`define BOOT_LOADER_MAP_SVH
`define APP_START_ADDR        16'h0000
`define FACTORY_BOOT_PC       16'hF800
`define FACTORY_BOOT_STATUS   16'h8000
`define BOOT_ROM_BASE         16'hF800
`define STATUS_ERASED         8'h00
`define STATUS_ERROR_MARK     8'hFF
`define VECTOR_ERASED         16'hFFFF
`define MAX_RECORD_BYTES      5'h10
`define REC_TYPE_DATA         8'h00
`define REC_TYPE_EOF          8'h01
`define CH_COLON              8'h3A
`define CH_CR                 8'h0D
`define CH_LF                 8'h0A
`define CH_BAUD               8'h66
`define CH_OK                 8'h2E
`define CH_CSUM_ERR           8'h58
`define CH_PROG_ERR           8'h52
`define IDLE_RESTART_NS       3000
`define CLK_PERIOD_NS         100
`define IDLE_RESTART_CYCLES   ((`IDLE_RESTART_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// >>> hdl/boot_loader_pkg.sv
// Types shared by the boot select loader
package boot_loader_pkg;
    typedef enum logic [2:0] {
        PS_WAIT_COLON,
        PS_HIGH_NIBBLE,
        PS_LOW_NIBBLE,
        PS_EXECUTE,
        PS_PROGRAM,
        PS_WAIT_END
    } parse_state_type;

    typedef enum logic [1:0] {
        BS_WAIT_START,
        BS_MEASURE,
        BS_LOCKED
    } baud_state_type;

    typedef struct packed {
        logic        valid;
        logic [15:0] addr;
        logic [7:0]  data;
    } flash_write_type;

    typedef struct packed {
        logic [15:0] program_counter;
        logic [15:0] status_word;
    } reset_vector_type;
endpackage

// >>> hdl/isp_boot_select_loader.sv
// Boot selection, flash idle control and serial hex record loader
//
// Overview of operation
// - Flash idle request powers flash down, adds 3us
// - Blank device enters built-in loader at power-up
// - Zero status byte starts at 0000H
// - Nonzero status byte loads boot vector
// - Factory vector: status 8000h, counter F800h
// - Programming error forces status byte nonzero
// - Erasing status byte or vector erases both
// - Strobe low, latch high, access high forces vector
// - Forced vector enables boot ROM
// - Loader disables watchdog before programming
// - Baud set by timing one received bit; the code times the start bit plus bit 0 and halves the count
// - Every received character is echoed
// - Hex record format, at most 16 bytes
// - Type 00 data, 01 end of file
// - Act only after whole record arrives
// - Bad checksum answers X, no execute
// - Good record answers period
// - Data byte failure answers R
// - Boot ROM enable from status or strapping
// - Boot ROM overlays F800 to FFFF
//
// Decided for this implementation: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "boot_loader_map.svh"

module isp_boot_select_loader
    import boot_loader_pkg::*;
#(
    parameter int BAUD_W = 16
)(
    input  wire logic             core_clk,
    input  wire logic             rst,
    input  wire logic             program_store_strobe_n,
    input  wire logic             address_latch_pin,
    input  wire logic             external_access_pin,
    input  wire logic             serial_rx,
    output logic                  serial_tx,
    input  wire logic             flash_idle_request,
    input  wire logic             cpu_idle,
    output logic                  flash_powered_down,
    output logic                  cpu_restart_hold,
    input  wire logic             erase_boot_cells,
    input  wire logic             write_status_byte,
    input  wire logic             write_boot_vector,
    input  wire logic [7:0]       cell_status_byte,
    input  wire reset_vector_type cell_boot_vector,
    output logic                  boot_rom_enable,
    output reset_vector_type      start_vector,
    output logic                  loader_active,
    output logic                  watchdog_disable,
    output flash_write_type       flash_write,
    input  wire logic             flash_write_ok,
    input  wire logic [15:0]      fetch_addr,
    output logic                  fetch_from_boot_rom,
    output logic [7:0]            status_byte,
    output reset_vector_type      boot_vector
);

    localparam int IDLE_CYC = `IDLE_RESTART_CYCLES;

    typedef struct packed {
        logic [2:0]       sync_strobe;
        logic [2:0]       sync_latch;
        logic [2:0]       sync_access;
        logic [2:0]       sync_rx;
        logic             rst_seen;
        logic [7:0]       status;
        reset_vector_type vector;
        logic             boot_rom_en;
        reset_vector_type start;
        logic             loader;
        logic             flash_down;
        logic [5:0]       idle_cnt;
        logic             restart_hold;
        baud_state_type   baud_st;
        logic [BAUD_W-1:0] bit_cycles;
        logic [BAUD_W-1:0] rx_cnt;
        logic [3:0]       rx_bit;
        logic             rx_busy;
        logic [7:0]       rx_shift;
        logic [BAUD_W-1:0] tx_cnt;
        logic [3:0]       tx_bit;
        logic [9:0]       tx_shift;
        logic [7:0]       tx_pend;
        logic             tx_pend_v;
        logic [7:0]       reply;
        logic             reply_v;
        parse_state_type  ps;
        logic [3:0]       hi_nib;
        logic [4:0]       byte_idx;
        logic [7:0]       rec_len;
        logic [15:0]      rec_addr;
        logic [7:0]       rec_type;
        logic [7:0]       csum;
        logic [4:0]       prog_idx;
        logic             prog_fail;
        logic             wr_wait;
        flash_write_type  fw;
        logic             tx_line;
    } state_type;

    state_type q, d;
    logic [15:0][7:0] rec_data_q;
    logic [15:0][7:0] rec_data_d;

    function automatic logic [4:0] hex_value(input logic [7:0] c);
        if (c >= 8'h30 && c <= 8'h39)
            hex_value = {1'b0, 4'(c - 8'h30)};
        else if (c >= 8'h41 && c <= 8'h46)
            hex_value = {1'b0, 4'(c - 8'h37)};
        else if (c >= 8'h61 && c <= 8'h66)
            hex_value = {1'b0, 4'(c - 8'h57)};
        else
            hex_value = 5'h10;
    endfunction

    always_comb
    begin
        logic       rx_done;
        logic [7:0] rx_char;
        logic [4:0] nib;
        logic [7:0] full_byte;
        logic       strap;
        rx_done   = 1'b0;
        rx_char   = 8'h00;
        nib       = 5'h00;
        full_byte = 8'h00;
        strap     = !q.sync_strobe[1] && q.sync_latch[1] && q.sync_access[1];
        d          = q;
        rec_data_d = rec_data_q;
        d.sync_strobe = {q.sync_strobe[1:0], program_store_strobe_n};
        d.sync_latch  = {q.sync_latch[1:0], address_latch_pin};
        d.sync_access = {q.sync_access[1:0], external_access_pin};
        d.sync_rx     = {q.sync_rx[1:0], serial_rx};
        d.fw.valid    = 1'b0;

        // Cell writes; erase clears both cells together
        if (erase_boot_cells)
        begin
            d.status = `STATUS_ERASED;
            d.vector = {`VECTOR_ERASED, `VECTOR_ERASED};
        end
        else
        begin
            if (write_status_byte)
                d.status = cell_status_byte;
            if (write_boot_vector)
                d.vector = cell_boot_vector;
        end

        // Boot choice sampled during reset, applied at its release
        if (q.rst_seen)
        begin
            d.rst_seen = 1'b0;
            if (q.status != `STATUS_ERASED || strap)
            begin
                d.boot_rom_en = 1'b1;
                d.start       = q.vector;
                d.loader      = 1'b1;
            end
            else
            begin
                d.boot_rom_en = 1'b0;
                d.start       = {`APP_START_ADDR, 16'h0000};
                d.loader      = 1'b0;
            end
        end

        // Flash idle and restart stretch
        if (cpu_idle && flash_idle_request)
            d.flash_down = 1'b1;
        if (q.flash_down && !cpu_idle)
        begin
            d.flash_down   = 1'b0;
            d.idle_cnt     = 6'(IDLE_CYC);
            d.restart_hold = 1'b1;
        end
        else if (q.idle_cnt != 6'h00)
            d.idle_cnt = q.idle_cnt - 6'h01;
        if (q.idle_cnt == 6'h01 && d.idle_cnt == 6'h00)
            d.restart_hold = 1'b0;

        // Receiver: baud measured on the start bit and first data bit of the first char
        case (q.baud_st)
            BS_WAIT_START:
                if (q.loader && !q.sync_rx[1])
                begin
                    d.baud_st    = BS_MEASURE;
                    d.bit_cycles = BAUD_W'(1);
                end
            BS_MEASURE:
                if (!q.sync_rx[1])
                    d.bit_cycles = q.bit_cycles + BAUD_W'(1);
                else
                begin
                    // f starts with two low bits; its rest is received
                    d.baud_st    = BS_LOCKED;
                    d.bit_cycles = q.bit_cycles >> 1;
                    d.rx_busy    = 1'b1;
                    d.rx_bit     = 4'h2;
                    d.rx_shift   = 8'h00;
                    d.rx_cnt     = q.bit_cycles >> 2;
                end
            default:
            begin
                if (!q.rx_busy)
                begin
                    if (!q.sync_rx[1])
                    begin
                        d.rx_busy = 1'b1;
                        d.rx_bit  = 4'h0;
                        d.rx_cnt  = q.bit_cycles >> 1;
                    end
                end
                else if (q.rx_cnt != '0)
                    d.rx_cnt = q.rx_cnt - BAUD_W'(1);
                else
                begin
                    d.rx_cnt = q.bit_cycles;
                    d.rx_bit = q.rx_bit + 4'h1;
                    if (q.rx_bit >= 4'h1 && q.rx_bit <= 4'h8)
                        d.rx_shift = {q.sync_rx[1], q.rx_shift[7:1]};
                    if (q.rx_bit == 4'h9)
                    begin
                        d.rx_busy = 1'b0;
                        rx_done   = 1'b1;
                        rx_char   = q.rx_shift;
                    end
                end
            end
        endcase

        // Echo queue; a reply waits behind the echo
        if (rx_done)
        begin
            d.tx_pend   = rx_char;
            d.tx_pend_v = 1'b1;
        end
        if (q.tx_bit == 4'h0)
        begin
            if (q.tx_pend_v)
            begin
                d.tx_shift  = {1'b1, q.tx_pend, 1'b0};
                d.tx_bit    = 4'hA;
                d.tx_cnt    = q.bit_cycles;
                d.tx_pend_v = rx_done;
            end
            else if (q.reply_v)
            begin
                d.tx_shift = {1'b1, q.reply, 1'b0};
                d.tx_bit   = 4'hA;
                d.tx_cnt   = q.bit_cycles;
                d.reply_v  = 1'b0;
            end
        end
        else if (q.tx_cnt != '0)
            d.tx_cnt = q.tx_cnt - BAUD_W'(1);
        else
        begin
            d.tx_line  = q.tx_shift[0];
            d.tx_shift = {1'b1, q.tx_shift[9:1]};
            d.tx_bit   = q.tx_bit - 4'h1;
            d.tx_cnt   = q.bit_cycles;
        end
        if (q.tx_bit == 4'h0)
            d.tx_line = 1'b1;
        else if (q.tx_cnt == q.bit_cycles)
            d.tx_line = q.tx_shift[0];

        // Record parser
        nib       = hex_value(rx_char);
        full_byte = {q.hi_nib, nib[3:0]};
        case (q.ps)
            PS_WAIT_COLON:
                if (rx_done && rx_char == `CH_COLON)
                begin
                    d.ps       = PS_HIGH_NIBBLE;
                    d.byte_idx = 5'h00;
                    d.csum     = 8'h00;
                end
            PS_HIGH_NIBBLE:
                if (rx_done)
                begin
                    if (nib[4])
                        d.ps = PS_WAIT_END;
                    else
                    begin
                        d.hi_nib = nib[3:0];
                        d.ps     = PS_LOW_NIBBLE;
                    end
                end
            PS_LOW_NIBBLE:
                if (rx_done)
                begin
                    if (nib[4])
                        d.ps = PS_WAIT_END;
                    else
                    begin
                        d.csum     = q.csum + full_byte;
                        d.byte_idx = q.byte_idx + 5'h1;
                        d.ps       = PS_HIGH_NIBBLE;
                        case (q.byte_idx)
                            5'h00: d.rec_len = full_byte;
                            5'h01: d.rec_addr[15:8] = full_byte;
                            5'h02: d.rec_addr[7:0] = full_byte;
                            5'h03: d.rec_type = full_byte;
                            default:
                                if (q.byte_idx - 5'h4 < 5'(q.rec_len))
                                    rec_data_d[4'(q.byte_idx - 5'h4)] =
                                        full_byte;
                        endcase
                        if (q.byte_idx == 5'h00 &&
                            full_byte > 8'(`MAX_RECORD_BYTES))
                            d.ps = PS_WAIT_END;
                        else if (q.byte_idx >= 5'h4 &&
                            q.byte_idx - 5'h4 == 5'(q.rec_len))
                            d.ps = PS_EXECUTE;
                    end
                end
            PS_EXECUTE:
            begin
                d.prog_idx  = 5'h00;
                d.prog_fail = 1'b0;
                d.wr_wait   = 1'b0;
                if (q.csum != 8'h00)
                begin
                    d.reply   = `CH_CSUM_ERR;
                    d.reply_v = 1'b1;
                    d.ps      = PS_WAIT_END;
                end
                else if (q.rec_type == `REC_TYPE_DATA)
                    d.ps = PS_PROGRAM;
                else
                begin
                    d.reply   = `CH_OK;
                    d.reply_v = 1'b1;
                    d.ps      = PS_WAIT_END;
                end
            end
            PS_PROGRAM:
                if (q.wr_wait)
                begin
                    d.wr_wait = 1'b0;
                    if (!flash_write_ok)
                        d.prog_fail = 1'b1;
                end
                else if (q.prog_idx < 5'(q.rec_len))
                begin
                    d.fw.valid = 1'b1;
                    d.fw.addr  = q.rec_addr + 16'(q.prog_idx);
                    d.fw.data  = rec_data_q[4'(q.prog_idx)];
                    d.prog_idx = q.prog_idx + 5'h1;
                    d.wr_wait  = 1'b1;
                end
                else
                begin
                    d.reply   = q.prog_fail ? `CH_PROG_ERR : `CH_OK;
                    d.reply_v = 1'b1;
                    if (q.prog_fail)
                        d.status = `STATUS_ERROR_MARK;
                    d.ps = PS_WAIT_END;
                end
            default:
                if (rx_done && (rx_char == `CH_LF ||
                    rx_char == `CH_COLON))
                    d.ps = (rx_char == `CH_COLON) ? PS_HIGH_NIBBLE
                                                  : PS_WAIT_COLON;
        endcase
        if (q.ps == PS_WAIT_END && rx_done && rx_char == `CH_COLON)
        begin
            d.byte_idx = 5'h00;
            d.csum     = 8'h00;
        end

        if (rst)
        begin
            d            = '0;
            d.rst_seen   = 1'b1;
            d.status     = q.status;
            d.vector     = q.vector;
            d.sync_strobe = {q.sync_strobe[1:0], program_store_strobe_n};
            d.sync_latch  = {q.sync_latch[1:0], address_latch_pin};
            d.sync_access = {q.sync_access[1:0], external_access_pin};
            d.sync_rx     = {q.sync_rx[1:0], serial_rx};
            d.tx_line    = 1'b1;
        end
    end

    // Unset power flag loads factory cells, so a fresh device boots loader
    logic powered_q;
    always_ff @(posedge core_clk)
    begin
        powered_q  <= 1'b1;
        rec_data_q <= rec_data_d;
        if (powered_q)
            q <= d;
        else
        begin
            q        <= '0;
            q.status <= `STATUS_ERROR_MARK;
            q.vector <= {`FACTORY_BOOT_PC, `FACTORY_BOOT_STATUS};
            q.rst_seen <= 1'b1;
            q.tx_line  <= 1'b1;
        end
    end

    assign serial_tx           = q.tx_line;
    assign flash_powered_down  = q.flash_down;
    assign cpu_restart_hold    = q.restart_hold;
    assign boot_rom_enable     = q.boot_rom_en;
    assign start_vector        = q.start;
    assign loader_active       = q.loader;
    assign watchdog_disable    = q.loader;
    assign flash_write         = q.fw;
    assign fetch_from_boot_rom = q.boot_rom_en &&
                                 fetch_addr >= `BOOT_ROM_BASE;
    assign status_byte         = q.status;
    assign boot_vector         = q.vector;

endmodule // isp_boot_select_loader
`default_nettype wire

// >>> tb/isp_boot_select_loader_assertions.sv
// Port-level checker for the boot select loader
`timescale 1ns/1ps
`default_nettype none
`include "boot_loader_map.svh"

module isp_boot_select_loader_assertions
    import boot_loader_pkg::*;
(
    input wire logic             core_clk,
    input wire logic             rst,
    input wire logic             program_store_strobe_n,
    input wire logic             address_latch_pin,
    input wire logic             external_access_pin,
    input wire logic             serial_rx,
    input wire logic             serial_tx,
    input wire logic             flash_idle_request,
    input wire logic             cpu_idle,
    input wire logic             flash_powered_down,
    input wire logic             cpu_restart_hold,
    input wire logic             erase_boot_cells,
    input wire logic             write_status_byte,
    input wire logic             write_boot_vector,
    input wire logic [7:0]       cell_status_byte,
    input wire reset_vector_type cell_boot_vector,
    input wire logic             boot_rom_enable,
    input wire reset_vector_type start_vector,
    input wire logic             loader_active,
    input wire logic             watchdog_disable,
    input wire flash_write_type  flash_write,
    input wire logic             flash_write_ok,
    input wire logic [15:0]      fetch_addr,
    input wire logic             fetch_from_boot_rom,
    input wire logic [7:0]       status_byte,
    input wire reset_vector_type boot_vector
);
    int hold_cnt_q;

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);

    // Counts high samples so the falling edge can judge the stretch
    always_ff @(posedge core_clk)
    begin
        if (rst || !cpu_restart_hold)
            hold_cnt_q <= 0;
        else
            hold_cnt_q <= hold_cnt_q + 1;
    end

    property p_rom_window;
        fetch_from_boot_rom == (boot_rom_enable && fetch_addr >= 16'hF800);
    endproperty
    a_rom_window: assert property (p_rom_window)
        else $error("boot rom overlay decode wrong");
    property p_wdog_write;
        flash_write.valid |-> watchdog_disable && loader_active;
    endproperty
    a_wdog_write: assert property (p_wdog_write)
        else $error("flash write with watchdog running");
    property p_erase;
        erase_boot_cells |=> status_byte == 8'h00
            && boot_vector == {16'hFFFF, 16'hFFFF};
    endproperty
    a_erase: assert property (p_erase)
        else $error("erase did not clear both cells");
    property p_prog_err;
        flash_write.valid && !flash_write_ok |-> ##[1:40] status_byte == 8'hFF;
    endproperty
    a_prog_err: assert property (p_prog_err)
        else $error("failed write left status byte zero");
    property p_idle_down;
        flash_idle_request && cpu_idle |-> ##[1:3] flash_powered_down;
    endproperty
    a_idle_down: assert property (p_idle_down)
        else $error("flash not powered down in idle");
    property p_restart;
        $fell(cpu_restart_hold) |-> hold_cnt_q == `IDLE_RESTART_CYCLES;
    endproperty
    a_restart: assert property (p_restart)
        else $error("restart hold length wrong");
    property p_boot_rom;
        $fell(rst) && status_byte != 8'h00 |=> boot_rom_enable
            && loader_active && start_vector == boot_vector;
    endproperty
    a_boot_rom: assert property (p_boot_rom)
        else $error("nonzero status did not select boot vector");
    property p_app_start;
        $fell(rst) && status_byte == 8'h00 && program_store_strobe_n
            |=> !boot_rom_enable && start_vector.program_counter == 16'h0000;
    endproperty
    a_app_start: assert property (p_app_start)
        else $error("zero status did not start application");

    c_write: cover property (flash_write.valid);
    c_restart: cover property ($fell(cpu_restart_hold));
    c_erase: cover property (erase_boot_cells);
endmodule // isp_boot_select_loader_assertions
`default_nettype wire

// >>> tb/host_uart_model.sv
// Host programmer model: serial sender and echo receiver
`timescale 1ns/1ps
`default_nettype none

module host_uart_model #(
    parameter int BIT_CYC = 48
)(
    input  wire logic core_clk,
    input  wire logic serial_tx,
    output logic      serial_rx
);
    logic [7:0] rx_q[$];

    initial serial_rx = 1'b1;

    // Two idle bits per frame keep the echo from backing up
    task automatic send_byte(input logic [7:0] b);
        logic [9:0] frame;
        frame = {1'b1, b, 1'b0};
        @(posedge core_clk);
        for (int i = 0; i < 10; i++)
        begin
            serial_rx <= frame[i]; // LSB first, idle high
            repeat (BIT_CYC) @(posedge core_clk);
        end
        repeat (2 * BIT_CYC) @(posedge core_clk);
    endtask

    // Device bit time runs one clock longer than the measured one
    always
    begin : rx_side
        logic [7:0] b;
        @(negedge serial_tx);
        repeat (BIT_CYC / 2) @(posedge core_clk);
        for (int i = 0; i < 8; i++)
        begin
            repeat (BIT_CYC + 1) @(posedge core_clk);
            b[i] = serial_tx;
        end
        repeat (BIT_CYC / 2) @(posedge core_clk);
        rx_q.push_back(b);
    end
endmodule // host_uart_model
`default_nettype wire

// >>> tb/isp_boot_select_loader_tb.sv
// Self-checking bench for the boot select loader
`timescale 1ns/1ps
`default_nettype none
`include "boot_loader_map.svh"

module isp_boot_select_loader_tb
    import boot_loader_pkg::*;
;
    localparam int BIT_CYC = 48;
    logic core_clk = 1'b0, rst = 1'b1, program_store_strobe_n = 1'b1;
    logic address_latch_pin = 1'b1, external_access_pin = 1'b0;
    logic flash_idle_request = 1'b0, cpu_idle = 1'b0, flash_write_ok = 1'b1;
    logic erase_boot_cells = 1'b0, write_status_byte = 1'b0;
    logic write_boot_vector = 1'b0;
    logic [7:0] cell_status_byte = 8'h00;
    logic [15:0] fetch_addr = 16'h0000;
    reset_vector_type cell_boot_vector = {16'hF800, 16'h8000};
    logic serial_rx, serial_tx, flash_powered_down, cpu_restart_hold;
    logic boot_rom_enable, loader_active, watchdog_disable;
    logic fetch_from_boot_rom;
    logic [7:0] status_byte;
    reset_vector_type start_vector, boot_vector;
    flash_write_type flash_write;
    int failures = 0;
    int cmp_count = 0;
    logic [23:0] wr_q[$];

    always #50 core_clk = ~core_clk;

    isp_boot_select_loader #(.BAUD_W(16)) dut (.*);

    host_uart_model #(.BIT_CYC(BIT_CYC)) host (.*);

    always @(posedge core_clk)
        if (flash_write.valid === 1'b1)
            wr_q.push_back({flash_write.addr, flash_write.data});

    task automatic check_val(input string what, input logic [31:0] exp,
                             input logic [31:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            failures++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic wait_high(input string what, ref logic sig);
        int n = 0;
        while (sig !== 1'b1)
        begin
            @(negedge core_clk);
            n++;
            if (n > 20)
            begin
                check_val(what, 1, 0);
                print_verdict();
            end
        end
    endtask

    task automatic do_reset(input logic strap);
        @(posedge core_clk);
        rst <= 1'b1;
        program_store_strobe_n <= !strap;
        external_access_pin <= strap;
        repeat (5) @(posedge core_clk);
        rst <= 1'b0;
        repeat (2) @(posedge core_clk);
        program_store_strobe_n <= 1'b1; // strobe freed after reset
        @(negedge core_clk);
    endtask

    task automatic check_fetch(input logic [15:0] a, input logic exp);
        @(posedge core_clk);
        fetch_addr <= a;
        @(negedge core_clk);
        check_val("fetch from rom", exp, fetch_from_boot_rom);
    endtask

    // Reply may land anywhere among the echoes, so it is picked out
    task automatic run_record(input string s, input logic [7:0] reply);
        logic [7:0] got = 8'h00;
        int k = 0;
        int n = 0;
        host.rx_q.delete();
        wr_q.delete();
        foreach (s[i])
            host.send_byte(s[i]);
        while (host.rx_q.size() < s.len() + (reply != 8'h00) && n < 1000)
        begin
            @(posedge core_clk);
            n++;
        end
        repeat (12 * BIT_CYC) @(posedge core_clk);
        foreach (host.rx_q[i])
            if (host.rx_q[i] inside {`CH_OK, `CH_CSUM_ERR, `CH_PROG_ERR})
                got = host.rx_q[i];
            else
            begin
                check_val("echo", (k < s.len()) ? s[k] : 8'h00, host.rx_q[i]);
                k++;
            end
        check_val("echo count", s.len(), k);
        check_val("reply", reply, got);
    endtask

    task automatic t_power_up();
        check_val("status", 8'hFF, status_byte);
        check_val("vector", {16'hF800, 16'h8000}, boot_vector);
        check_val("start", {16'hF800, 16'h8000}, start_vector);
        check_val("rom enable", 1, boot_rom_enable);
        check_val("watchdog off", 1, watchdog_disable);
        check_fetch(16'hF800, 1'b1);
        check_fetch(16'hF7FF, 1'b0);
    endtask

    task automatic t_boot_select();
        @(posedge core_clk);
        erase_boot_cells <= 1'b1; // host clears status after load
        @(posedge core_clk);
        erase_boot_cells <= 1'b0;
        @(negedge core_clk);
        check_val("status", 8'h00, status_byte);
        check_val("vector", 32'hFFFFFFFF, boot_vector);
        do_reset(1'b0);
        check_val("rom enable", 0, boot_rom_enable);
        check_val("loader", 0, loader_active);
        check_val("start pc", 16'h0000, start_vector.program_counter);
        check_fetch(16'hF800, 1'b0);
        @(posedge core_clk);
        write_boot_vector <= 1'b1;
        @(posedge core_clk);
        write_boot_vector <= 1'b0;
        @(negedge core_clk);
        check_val("vector", {16'hF800, 16'h8000}, boot_vector);
        do_reset(1'b1);
        check_val("rom enable", 1, boot_rom_enable);
        check_val("loader", 1, loader_active);
        check_val("start", {16'hF800, 16'h8000}, start_vector);
    endtask

    task automatic t_loader();
        host.send_byte(`CH_BAUD);
        repeat (12 * BIT_CYC) @(posedge core_clk);
        check_val("baud echo", `CH_BAUD, host.rx_q[0]);
        run_record(":00000001FF\015\012", `CH_OK);
        run_record(":02123400AB5CB1\015\012", `CH_OK);
        check_val("writes", 2, wr_q.size());
        check_val("write 0", 24'h1234AB, wr_q[0]);
        check_val("write 1", 24'h12355C, wr_q[1]);
        run_record(":02123400AB5CB2\015\012", `CH_CSUM_ERR);
        check_val("writes", 0, wr_q.size());
        @(posedge core_clk);
        flash_write_ok <= 1'b0;
        run_record(":01000000AA55\015\012", `CH_PROG_ERR);
        check_val("status", 8'hFF, status_byte);
        flash_write_ok <= 1'b1;
        run_record("ZZ:1100000\015\012", 8'h00);
    endtask

    task automatic t_idle();
        int n = 0;
        @(posedge core_clk);
        flash_idle_request <= 1'b1; // set just before idle
        @(posedge core_clk);
        cpu_idle <= 1'b1;
        wait_high("flash down", flash_powered_down);
        repeat (20) @(posedge core_clk);
        cpu_idle <= 1'b0;
        wait_high("restart hold", cpu_restart_hold);
        while (cpu_restart_hold === 1'b1 && n < 100)
        begin
            @(negedge core_clk);
            n++;
        end
        check_val("hold cycles", `IDLE_RESTART_CYCLES, n);
        @(posedge core_clk);
        flash_idle_request <= 1'b0;
    endtask

    initial
    begin
        repeat (5) @(posedge core_clk);
        rst <= 1'b0;
        repeat (2) @(posedge core_clk);
        @(negedge core_clk);
        t_power_up();
        t_boot_select();
        t_loader();
        t_idle();
        print_verdict();
    end
endmodule // isp_boot_select_loader_tb

bind isp_boot_select_loader isp_boot_select_loader_assertions chk (.*);
`default_nettype wire
